/* File: shared/bwcl_if.sv */
// link between the configuration controller and the loader
// assumes the bench resolves the open-drain clear-status wire from the enables
`timescale 1ns/1ps
interface bwcl_if;
    logic       config_clock;
    logic       select_b;
    logic       write_b;
    logic [7:0] data_to_dev;
    logic       data_to_dev_oe;
    logic [7:0] data_from_dev;
    logic       data_from_dev_oe;
    logic       busy;
    logic       program_b;
    logic       clear_status_in;
    logic       clear_status_dev_oe;
    logic       clear_status_host_oe;
    logic       done;
    modport device (input config_clock, select_b, write_b, data_to_dev, program_b, clear_status_in,
                    output data_from_dev, data_from_dev_oe, busy, clear_status_dev_oe, done);
    modport host (output config_clock, select_b, write_b, data_to_dev, data_to_dev_oe, program_b,
                  clear_status_host_oe, input data_from_dev, busy, clear_status_in, done);
endinterface

/* File: shared/bwcl_pkg.sv */
// shared constants for the byte-wide configuration loader and its controller
// assumes both ends run on a 50 MHz ref_clk and the link clock is sampled, not used as a clock
package bwcl_pkg;
    // reference clock and link timing
    localparam int REF_CLK_MHZ              = 50;
    localparam int NO_HANDSHAKE_CLOCK_LIMIT = 50;   // MHz
    localparam int LINK_HALF_PERIOD_NS      = 80;
    localparam int LINK_HALF_CYCLES         = (LINK_HALF_PERIOD_NS * REF_CLK_MHZ) / 1000;
    // mode pin codes
    localparam logic [2:0] MODE_TAP_ONLY_A  = 3'h5;
    localparam logic [2:0] MODE_TAP_ONLY_B  = 3'h1;
    // sequencer counts: clear in ref_clk cycles, busy and abort in link clock rises, tap in tck rises
    localparam logic [7:0] CLEAR_CYCLES     = 8'h20;
    localparam logic [3:0] BUSY_CYCLES      = 4'h3;
    localparam logic [3:0] ABORT_CYCLES     = 4'h6;
    localparam logic [7:0] TAP_SHIFT_BITS   = 8'h08;
    // bitstream framing
    localparam logic [31:0] SYNC_WORD       = 32'haa995566;
    localparam logic [31:0] START_WORD      = 32'h0000000d;  // arbitrary end-of-load command
    // controller register offsets (byte addresses)
    localparam logic [3:0] REG_CTRL         = 4'h0;
    localparam logic [3:0] REG_DATA         = 4'h4;
    localparam logic [3:0] REG_STATUS       = 4'h8;
    localparam logic [3:0] REG_READ         = 4'hc;
    // control register fields
    localparam int CTRL_SELECT              = 0;
    localparam int CTRL_WRITE               = 1;
    localparam int CTRL_PROGRAM             = 2;
    localparam int CTRL_HOLD_CLEAR          = 3;
    localparam int CTRL_RUN_CLOCK           = 4;
    localparam logic [4:0] CTRL_RESET       = 5'h00;
    typedef enum logic [2:0] {CFG_CLEAR, CFG_WAIT_INIT, CFG_LOAD, CFG_START, CFG_DONE} bwcl_phase_type;
endpackage

/* File: src/bwcl_device.sv */
// configuration loader: byte port, tap load path, clear/load/start-up sequencer
// assumes link pins are asynchronous to ref_clk and sampled twice before use
`timescale 1ns/1ps
module bwcl_device (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    // link
    bwcl_if.device          lnk,
    // straps and options
    input  wire logic [2:0] mode_select_pins,
    input  wire logic       fast_clock,
    input  wire logic       keep_port,
    input  wire logic       release_delay,
    input  wire logic       wait_all_done,
    input  wire logic       wait_lock,
    input  wire logic       all_done_in,
    input  wire logic       lock_in,
    // test access port load path
    input  wire logic       tap_load_active,
    input  wire logic       tap_startup_active,
    input  wire logic       tck,
    input  wire logic       tdi,
    // user side
    output logic [7:0]      cfg_byte,
    output logic            cfg_byte_valid,
    output logic            port_released,
    output logic            global_output_tristate,
    output logic            global_set_reset,
    output logic            global_write_enable
);
    // two-stage synchronisers for every link, tap and status pin input; mode pins and straps are used directly
    logic [12:0] s1_q, s2_q;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_q <= 13'h1e06;
            s2_q <= 13'h1e06;
        end else begin
            s1_q <= {lnk.program_b, lnk.clear_status_in, lnk.select_b, lnk.write_b, lnk.config_clock,
                     tck, tdi, tap_load_active, tap_startup_active, all_done_in, lock_in, 2'h2};
            s2_q <= s1_q;
        end
    end
    logic prog_b_s, clr_s, sel_b_s, wr_b_s, config_clock_s, tck_s, tdi_s, tapld_s, tapst_s, alld_s, lock_s;
    assign {prog_b_s, clr_s, sel_b_s, wr_b_s, config_clock_s, tck_s, tdi_s, tapld_s, tapst_s, alld_s, lock_s} = s2_q[12:2];
    logic [7:0] d1_q, d2_q;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            d1_q <= 8'h00;
            d2_q <= 8'h00;
        end else begin
            d1_q <= lnk.data_to_dev;
            d2_q <= d1_q;
        end
    end
    // edge detection on sampled clocks
    logic config_clock_q, tck_q;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            config_clock_q <= 1'b0;
            tck_q  <= 1'b0;
        end else begin
            config_clock_q <= config_clock_s;
            tck_q  <= tck_s;
        end
    end
    logic config_clock_rise, tck_rise, tap_only;
    assign config_clock_rise = config_clock_s && !config_clock_q;
    assign tck_rise  = tck_s && !tck_q;
    assign tap_only  = (mode_select_pins == bwcl_pkg::MODE_TAP_ONLY_A) ||
                       (mode_select_pins == bwcl_pkg::MODE_TAP_ONLY_B);

    // phase sequencer
    bwcl_pkg::bwcl_phase_type phase_q;
    logic [7:0] clr_cnt_q;
    logic       load_end;
    logic [1:0] rel_q;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_q   <= bwcl_pkg::CFG_CLEAR;
            clr_cnt_q <= 8'h00;
        end else if (!prog_b_s) begin
            phase_q   <= bwcl_pkg::CFG_CLEAR;
            clr_cnt_q <= 8'h00;
        end else begin
            case (phase_q)
                bwcl_pkg::CFG_CLEAR: begin
                    clr_cnt_q <= clr_cnt_q + 8'h01;
                    if (clr_cnt_q == bwcl_pkg::CLEAR_CYCLES) phase_q <= bwcl_pkg::CFG_WAIT_INIT;
                end
                bwcl_pkg::CFG_WAIT_INIT: if (clr_s) phase_q <= bwcl_pkg::CFG_LOAD;
                bwcl_pkg::CFG_LOAD:      if (load_end) phase_q <= bwcl_pkg::CFG_START;
                bwcl_pkg::CFG_START:     if (rel_q == 2'h3) phase_q <= bwcl_pkg::CFG_DONE;
                bwcl_pkg::CFG_DONE:      phase_q <= bwcl_pkg::CFG_DONE;
                default:                 phase_q <= bwcl_pkg::CFG_CLEAR;
            endcase
        end
    end

    // byte port: direction tracking, abort and busy
    logic       prev_sel_q, prev_wr_q, aligned_q, busy_q;
    logic [3:0] busy_cnt_q;
    logic       byte_port_en, abort_now, write_edge, take_byte;
    assign byte_port_en = !tap_only && (phase_q == bwcl_pkg::CFG_LOAD);
    assign abort_now  = byte_port_en && config_clock_rise && !sel_b_s && prev_sel_q && (wr_b_s != prev_wr_q);
    assign write_edge = byte_port_en && config_clock_rise && !sel_b_s && !wr_b_s && !abort_now;
    assign take_byte  = write_edge && !busy_q;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_sel_q <= 1'b0;
            prev_wr_q  <= 1'b1;
        end else if (config_clock_rise) begin
            prev_sel_q <= !sel_b_s; // a fresh select starts clean, packet state is kept
            prev_wr_q  <= wr_b_s;
        end
    end
    // busy changes only right after a sampled rising link edge
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_q     <= 1'b0;
            busy_cnt_q <= 4'h0;
        end else if (abort_now) begin
            busy_q     <= 1'b1;
            busy_cnt_q <= bwcl_pkg::ABORT_CYCLES;
        end else if (take_byte && fast_clock) begin
            busy_q     <= 1'b1; // only above the no-handshake limit
            busy_cnt_q <= bwcl_pkg::BUSY_CYCLES;
        end else if (config_clock_rise && busy_q) begin
            busy_cnt_q <= busy_cnt_q - 4'h1;
            if (busy_cnt_q == 4'h1) busy_q <= 1'b0;
        end
    end

    // tap deserialiser produces bytes for the same packet stream
    logic [7:0] tap_sr_q, tap_cnt_q;
    logic       tap_byte;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tap_sr_q  <= 8'h00;
            tap_cnt_q <= 8'h00;
        end else if (tck_rise && tapld_s && phase_q == bwcl_pkg::CFG_LOAD) begin
            tap_sr_q  <= {tap_sr_q[6:0], tdi_s};
            tap_cnt_q <= (tap_cnt_q == bwcl_pkg::TAP_SHIFT_BITS - 8'h01) ? 8'h00 : tap_cnt_q + 8'h01;
        end
    end
    assign tap_byte = tck_rise && tapld_s && phase_q == bwcl_pkg::CFG_LOAD &&
                      tap_cnt_q == bwcl_pkg::TAP_SHIFT_BITS - 8'h01;
    logic [7:0] in_byte;
    assign in_byte = tap_byte ? {tap_sr_q[6:0], tdi_s} : d2_q;

    // word framing: hunt for sync after reset or abort
    logic [31:0] win_q;
    logic [31:0] win_d;
    logic        new_byte;
    assign new_byte = take_byte || tap_byte;
    assign win_d    = {win_q[23:0], in_byte};
    assign load_end = new_byte && aligned_q && win_d == bwcl_pkg::START_WORD;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            win_q     <= 32'h00000000;
            aligned_q <= 1'b0;
        end else if (abort_now || !prog_b_s) begin
            aligned_q <= 1'b0;
            win_q     <= 32'h00000000;
        end else if (new_byte) begin
            win_q <= win_d;
            if (win_d == bwcl_pkg::SYNC_WORD) aligned_q <= 1'b1;
        end
    end
    // accepted bytes pass to the user side only once aligned
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_byte       <= 8'h00;
            cfg_byte_valid <= 1'b0;
        end else begin
            cfg_byte_valid <= new_byte && aligned_q;
            if (new_byte) cfg_byte <= in_byte;
        end
    end

    // start-up release order, counted on link clock (or tck in tap start-up)
    logic step;
    assign step = (config_clock_rise || (tck_rise && tapst_s)) &&
                  (!wait_all_done || alld_s) && (!wait_lock || lock_s);
    logic extra_q;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rel_q   <= 2'h0;
            extra_q <= 1'b0;
        end else if (phase_q != bwcl_pkg::CFG_START && phase_q != bwcl_pkg::CFG_DONE) begin
            rel_q   <= 2'h0;
            extra_q <= 1'b0;
        end else if (step && rel_q != 2'h3) begin
            extra_q <= 1'b1; // optional one-edge stretch before the first release
            rel_q   <= (release_delay && !extra_q) ? rel_q : rel_q + 2'h1;
        end
    end
    // done rises at release step 1, tristate one edge later, set/reset and write enable one more
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            lnk.done               <= 1'b0;
            global_output_tristate <= 1'b1;
            global_set_reset       <= 1'b1;
            global_write_enable    <= 1'b0;
            lnk.clear_status_dev_oe <= 1'b1;
        end else begin
            lnk.done               <= rel_q != 2'h0;
            global_output_tristate <= rel_q < 2'h2;
            global_set_reset       <= rel_q != 2'h3;
            global_write_enable    <= rel_q == 2'h3;
            lnk.clear_status_dev_oe <= phase_q == bwcl_pkg::CFG_CLEAR;
        end
    end

    // readback drive and port release
    logic rb_drive;
    assign rb_drive = !tap_only && !sel_b_s && wr_b_s && (phase_q != bwcl_pkg::CFG_DONE || keep_port);
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            lnk.data_from_dev    <= 8'h00;
            lnk.data_from_dev_oe <= 1'b0;
            lnk.busy             <= 1'b0;
            port_released        <= 1'b0;
        end else begin
            lnk.data_from_dev_oe <= rb_drive;
            if (rb_drive && config_clock_rise) lnk.data_from_dev <= win_q[31:24];
            lnk.busy             <= busy_q;
            port_released        <= phase_q == bwcl_pkg::CFG_DONE && !keep_port;
        end
    end
endmodule

/* File: src/bwcl_host.sv */
// external configuration controller: avalon-mm registers drive the byte port
// assumes the bench joins it to the loader through bwcl_if
`timescale 1ns/1ps
module bwcl_host (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // link
    bwcl_if.host             lnk
);
    // synchronise device outputs
    logic [10:0] s1_q, s2_q;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_q <= 11'h000;
            s2_q <= 11'h000;
        end else begin
            s1_q <= {lnk.busy, lnk.done, lnk.clear_status_in, lnk.data_from_dev};
            s2_q <= s1_q;
        end
    end
    logic busy_s, done_s, clr_s;
    assign {busy_s, done_s, clr_s} = s2_q[10:8];

    // divider makes the link clock; half period in ref_clk cycles
    logic [7:0] div_q;
    logic       config_clock_q, fall_now, pend_q;
    logic [4:0] ctrl_q;
    assign fall_now = config_clock_q && div_q == 8'(bwcl_pkg::LINK_HALF_CYCLES - 1);
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_q  <= 8'h00;
            config_clock_q <= 1'b0;
        end else if ((ctrl_q[bwcl_pkg::CTRL_RUN_CLOCK] &&
                      (pend_q || !ctrl_q[bwcl_pkg::CTRL_WRITE] || !ctrl_q[bwcl_pkg::CTRL_SELECT])) || config_clock_q) begin
            // a selected writer clocks only with a byte pending, else every rise would load a stale byte
            if (div_q == 8'(bwcl_pkg::LINK_HALF_CYCLES - 1)) begin
                div_q  <= 8'h00;
                config_clock_q <= !config_clock_q;
            end else begin
                div_q <= div_q + 8'h01;
            end
        end
    end

    // byte to send: held on the pins while busy, pending clears only at a falling edge after the byte was taken
    logic [7:0] data_q;
    logic       sent_q;
    logic       bus_ack;
    assign bus_ack = !avs_waitrequest && (avs_read || avs_write);
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= bwcl_pkg::CTRL_RESET;
            data_q <= 8'h00;
            pend_q <= 1'b0;
        end else begin
            if (avs_write && bus_ack && avs_address == bwcl_pkg::REG_CTRL) ctrl_q <= avs_writedata[4:0];
            if (avs_write && bus_ack && avs_address == bwcl_pkg::REG_DATA) begin
                data_q <= avs_writedata[7:0];
                pend_q <= 1'b1;
            end else if (fall_now && sent_q) begin
                pend_q <= 1'b0; // byte seen at a rising edge with busy low
            end
        end
    end
    // a byte counts as sent once a rising edge passed with busy low
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sent_q <= 1'b0;
        end else if (!config_clock_q && div_q == 8'(bwcl_pkg::LINK_HALF_CYCLES - 1)) begin
            sent_q <= pend_q && !busy_s && ctrl_q[bwcl_pkg::CTRL_SELECT] && ctrl_q[bwcl_pkg::CTRL_WRITE];
        end
    end

    // select, write and data pins change only while the link clock is low so the device samples stable levels
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            lnk.select_b             <= 1'b1;
            lnk.write_b              <= 1'b1;
            lnk.data_to_dev          <= 8'h00;
            lnk.data_to_dev_oe       <= 1'b0;
            lnk.program_b            <= 1'b1;
            lnk.clear_status_host_oe <= 1'b0;
            lnk.config_clock         <= 1'b0;
        end else begin
            lnk.config_clock         <= config_clock_q;
            lnk.program_b            <= !ctrl_q[bwcl_pkg::CTRL_PROGRAM];
            lnk.clear_status_host_oe <= ctrl_q[bwcl_pkg::CTRL_HOLD_CLEAR];
            if (!config_clock_q) begin
                lnk.select_b       <= !ctrl_q[bwcl_pkg::CTRL_SELECT];
                lnk.write_b        <= !ctrl_q[bwcl_pkg::CTRL_WRITE];
                lnk.data_to_dev_oe <= ctrl_q[bwcl_pkg::CTRL_WRITE]; // never drive during readback
                if (!busy_s) lnk.data_to_dev <= data_q;
            end
        end
    end

    // avalon answers one cycle after the request is seen
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
            if (avs_read && avs_waitrequest) begin
                case (avs_address)
                    bwcl_pkg::REG_CTRL:   avs_readdata <= {27'h0, ctrl_q};
                    bwcl_pkg::REG_DATA:   avs_readdata <= {24'h0, data_q};
                    bwcl_pkg::REG_STATUS: avs_readdata <= {28'h0, pend_q, clr_s, done_s, busy_s};
                    bwcl_pkg::REG_READ:   avs_readdata <= {24'h0, s2_q[7:0]};
                    default:              avs_readdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule

/* File: verification/bwcl_sva.sv */
// checker for the link between controller and loader
// assumes it sees the interface wires directly, sampled on ref_clk
`timescale 1ns/1ps
module bwcl_sva (
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       rst_b,
    // link wires
    input wire logic       config_clock,
    input wire logic       select_b,
    input wire logic       write_b,
    input wire logic [7:0] data_to_dev,
    input wire logic       data_to_dev_oe,
    input wire logic       data_from_dev_oe,
    input wire logic       busy,
    input wire logic       clear_status_in,
    input wire logic       clear_status_dev_oe,
    input wire logic       done
);
    logic       clk_q;
    logic       sel_q;
    logic       wr_q;
    logic       ab_pend_q;
    logic [3:0] ab_rises_q;
    logic [3:0] since_rise_q;
    logic [3:0] rb_q;
    logic [7:0] clr_q;
    logic       link_rise;
    logic       abort_now;
    // link edges are seen on ref_clk, so every bound below allows for sampling lag
    assign link_rise = config_clock & ~clk_q;
    assign abort_now = link_rise & ~select_b & sel_q & (write_b != wr_q);
    // link edge history and abort tracking
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            clk_q <= 1'b0;
            sel_q <= 1'b0;
            wr_q <= 1'b1;
            ab_pend_q <= 1'b0;
            ab_rises_q <= 4'h0;
        end else begin
            clk_q <= config_clock;
            if (link_rise) begin
                sel_q <= ~select_b;
                wr_q <= write_b;
            end
            if (abort_now) begin
                ab_pend_q <= 1'b1;
                ab_rises_q <= 4'h0;
            end else if (link_rise && ab_rises_q != 4'hf) begin
                ab_rises_q <= ab_rises_q + 4'h1;
            end
            if (!busy && ab_pend_q && ab_rises_q > 4'h8) begin
                ab_pend_q <= 1'b0;
            end
        end
    end
    // saturating age counters
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            since_rise_q <= 4'hf;
            rb_q <= 4'hf;
            clr_q <= 8'h00;
        end else begin
            since_rise_q <= link_rise ? 4'h0 : (since_rise_q == 4'hf ? 4'hf : since_rise_q + 4'h1);
            rb_q <= (!select_b && write_b) ? 4'h0 : (rb_q == 4'hf ? 4'hf : rb_q + 4'h1);
            clr_q <= !clear_status_dev_oe ? 8'h00 : (clr_q == 8'hff ? 8'hff : clr_q + 8'h01);
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    sequence abort_seq;
        abort_now;
    endsequence
    sequence busy_after_abort;
        ##[1:12] busy;
    endsequence
    a_abort_busy: assert property (abort_seq |-> busy_after_abort)
        else $error("busy did not rise after a direction change");
    a_abort_hold: assert property ($fell(busy) && ab_pend_q |-> ab_rises_q >= 4'h5)
        else $error("busy dropped before the abort finished");
    a_busy_edge: assert property ($changed(busy) |-> since_rise_q <= 4'h8)
        else $error("busy changed away from a link clock rise");
    a_host_contend: assert property (data_to_dev_oe |-> !(!select_b && write_b))
        else $error("controller drives data during readback");
    a_hold_busy: assert property (busy && $past(busy) && !select_b |-> $stable(data_to_dev))
        else $error("data changed while busy");
    a_readback_cause: assert property (data_from_dev_oe |-> rb_q <= 4'h5)
        else $error("loader drives data without a readback request");
    a_clear_len: assert property ($fell(clear_status_dev_oe) |-> clr_q >= 8'd31)
        else $error("memory clear phase too short");
    a_done_init: assert property ($rose(done) |-> $past(clear_status_in) && !clear_status_dev_oe)
        else $error("done rose while clear status was held low");
endmodule

/* File: verification/byte_wide_config_loader_bench.sv */
// bench: controller and loader joined by the link, driven over avalon-mm
// assumes the controller makes the link clock itself from run_clock
`timescale 1ns/1ps
module byte_wide_config_loader_bench;
    logic        ref_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [31:0] rd;
    logic [31:0] seed = 32'hd71a6d1a;
    logic        fast_clock = 1'b0;
    logic        keep_port = 1'b1;
    logic        wait_lock = 1'b1;
    logic        lock_in = 1'b0;
    logic        release_delay = 1'b0;
    logic        all_done_in = 1'b1;
    logic [7:0]  cfg_byte;
    logic        cfg_byte_valid, port_released, g_tri, g_sr, g_we;
    int          bad_count = 0, n_tests = 0, cyc = 0, slow_busy = 0;
    logic [7:0]  exp_q[$];
    bwcl_if lnk ();
    // open-drain clear status: low whenever either end pulls
    assign lnk.clear_status_in = !(lnk.clear_status_dev_oe | lnk.clear_status_host_oe);
    always #10 ref_clk = ~ref_clk;
    bwcl_host bwcl_host_inst (.ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .lnk(lnk.host));
    bwcl_device bwcl_device_inst (.ref_clk(ref_clk), .rst_b(rst_b), .lnk(lnk.device), .mode_select_pins(3'h6),
        .fast_clock(fast_clock), .keep_port(keep_port), .release_delay(release_delay), .wait_all_done(wait_lock),
        .wait_lock(wait_lock), .all_done_in(all_done_in), .lock_in(lock_in), .tap_load_active(1'b0),
        .tap_startup_active(1'b0), .tck(1'b0), .tdi(1'b0), .cfg_byte(cfg_byte), .cfg_byte_valid(cfg_byte_valid),
        .port_released(port_released), .global_output_tristate(g_tri), .global_set_reset(g_sr),
        .global_write_enable(g_we));
    bwcl_sva bwcl_sva_inst (.ref_clk(ref_clk), .rst_b(rst_b), .config_clock(lnk.config_clock),
        .select_b(lnk.select_b), .write_b(lnk.write_b), .data_to_dev(lnk.data_to_dev),
        .data_to_dev_oe(lnk.data_to_dev_oe), .data_from_dev_oe(lnk.data_from_dev_oe), .busy(lnk.busy),
        .clear_status_in(lnk.clear_status_in), .clear_status_dev_oe(lnk.clear_status_dev_oe), .done(lnk.done));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // bus cycle: hold the request until waitrequest is seen low at an edge
    task av(input logic [3:0] a, input logic wr, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // poll one status bit with a bounded number of reads
    task wait_st(input int b, input logic v);
        for (int i = 0; i < 400; i++) begin
            av(bwcl_pkg::REG_STATUS, 1'b0, 32'h0);
            if (rd[b] === v) break;
        end
        check({31'h0, rd[b]}, {31'h0, v});
    endtask
    task send(input logic [7:0] b, input logic pass);
        if (pass) exp_q.push_back(b);
        av(bwcl_pkg::REG_DATA, 1'b1, {24'h0, b});
        wait_st(3, 1'b0);
    endtask
    task sync_word();
        for (int i = 3; i >= 0; i--) send(bwcl_pkg::SYNC_WORD[8*i+:8], 1'b0);
    endtask
    // result watcher, hang limit and slow-clock busy count
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            end_sim();
        end
        if (!fast_clock && lnk.busy === 1'b1) slow_busy++;
        if (cfg_byte_valid === 1'b1) begin
            if (exp_q.size() == 0) check(32'h1ff, {24'h0, cfg_byte});
            else check({24'h0, cfg_byte}, {24'h0, exp_q.pop_front()});
        end
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        wait_st(2, 1'b1);
        av(4'h1, 1'b0, 32'h0);
        check(rd, 32'h0);
        av(bwcl_pkg::REG_CTRL, 1'b1, 32'h13);
        sync_word();
        // packet split over two select assertions
        for (int i = 0; i < 10; i++) begin
            if (i == 5) av(bwcl_pkg::REG_CTRL, 1'b1, 32'h10);
            if (i == 5) av(bwcl_pkg::REG_CTRL, 1'b1, 32'h13);
            send(8'(xs()), 1'b1);
        end
        for (int i = 3; i >= 0; i--) send(bwcl_pkg::START_WORD[8*i+:8], 1'b1);
        // deselect so the link clock keeps running through start-up
        av(bwcl_pkg::REG_CTRL, 1'b1, 32'h10);
        check(slow_busy, 0);
        repeat (40) @(posedge ref_clk);
        check({31'h0, g_tri}, 32'h1);
        lock_in <= 1'b1;
        release_delay <= 1'b1;
        for (int i = 0; i < 200 && g_tri !== 1'b0; i++) @(posedge ref_clk);
        check({30'h0, lnk.done, g_sr}, 32'h3);
        for (int i = 0; i < 200 && g_sr !== 1'b0; i++) @(posedge ref_clk);
        check({30'h0, g_we, g_tri}, 32'h2);
        check({31'h0, port_released}, 32'h0);
        $display("test load and start-up done");
        // restart held by clear status, then abort and resync
        fast_clock <= 1'b1;
        av(bwcl_pkg::REG_CTRL, 1'b1, 32'h0c);
        av(bwcl_pkg::REG_CTRL, 1'b1, 32'h08);
        repeat (80) @(posedge ref_clk);
        av(bwcl_pkg::REG_STATUS, 1'b0, 32'h0);
        check({30'h0, rd[2:1]}, 32'h0);
        av(bwcl_pkg::REG_CTRL, 1'b1, 32'h10);
        wait_st(2, 1'b1);
        av(bwcl_pkg::REG_CTRL, 1'b1, 32'h13);
        sync_word();
        for (int i = 0; i < 2; i++) send(8'(xs()), 1'b1);
        av(bwcl_pkg::REG_CTRL, 1'b1, 32'h11);
        wait_st(0, 1'b1);
        wait_st(0, 1'b0);
        av(bwcl_pkg::REG_CTRL, 1'b1, 32'h13);
        for (int i = 0; i < 4; i++) send(8'(xs()), 1'b0);
        sync_word();
        for (int i = 0; i < 3; i++) send(8'(xs()), 1'b1);
        av(bwcl_pkg::REG_CTRL, 1'b1, 32'h11);
        repeat (30) @(posedge ref_clk);
        check({31'h0, lnk.data_from_dev_oe}, 32'h1);
        check(exp_q.size(), 0);
        $display("test abort and readback done");
        end_sim();
    end
endmodule
